// ===== rtl/vrseq_pkg.sv
// Shared constants and types of the regulator start-up and phase sequencer.
// Assumes a 50 MHz system clock and a classic Wishbone register bus.
package vrseq_pkg;

  // System clock rate
  localparam int CLK_HZ = 50_000_000;
  // Strap sampling delay after enable, in milliseconds
  localparam int STRAP_WAIT_MS = 8;
  // Same delay in clock cycles
  localparam int STRAP_WAIT_CYC = STRAP_WAIT_MS * (CLK_HZ / 1000);

  // Reference step size in microvolts per code
  localparam int REF_LSB_UV = 6250;
  // Reference level that ends standard buck mode, in millivolts
  localparam int SYNC_REF_MV = 480;
  // Highest code still at or below that level
  localparam logic [7:0] SYNC_REF_CODE = 8'((SYNC_REF_MV * 1000) / REF_LSB_UV);

  // Boot reference codes, one byte per two-pin boot pattern
  localparam logic [31:0] BOOT_TABLE = 32'hB0A09080;
  // Bits in one serial voltage command
  localparam logic [3:0] VID_CMD_BITS = 4'h8;
  // Bits in one telemetry word
  localparam logic [3:0] TELEM_BITS = 4'h8;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_VID = 8'h08;
  localparam logic [7:0] REG_STRAP = 8'h0C;

  // Control field positions
  localparam int CTRL_CCM_BIT = 0;
  localparam int CTRL_DIV_LSB = 8;
  // Control value after reset: continuous mode, slew divider 0x10
  localparam logic [15:0] CTRL_RESET = 16'h1001;

  // Sequencer states, Gray coded along the start-up path
  typedef enum logic [2:0] {
    VRSEQ_OFF = 3'b000,
    VRSEQ_STRAP = 3'b001,
    VRSEQ_RAMP = 3'b011,
    VRSEQ_GOOD = 3'b010,
    VRSEQ_RUN = 3'b110
  } vrseq_state_e;

  // Reference codes that travel together
  typedef struct packed {
    logic [1:0] boot;
    logic [7:0] target;
    logic [7:0] dac;
  } vrseq_vid_s;

  // Sampled configuration straps
  typedef struct packed {
    logic cfg_b;
    logic cfg_a;
  } vrseq_cfg_s;

endpackage : vrseq_pkg

// ===== rtl/vrseq_phase.sv
// One pulse channel: raises its pulse on its clock, drops it at the window level.
// Assumes the ripple input is already synchronised to clk_sys.
module vrseq_phase (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic phase_clk,
  input wire logic ripple_hit,
  input wire logic chan_on,
  input wire logic sync_mode,
  output logic pwm_out,
  output logic pwm_oe_n
);
  import vrseq_pkg::*;

  // Pulse level and pin drive enable
  always_ff @(posedge clk_sys) begin
    if (reset || !chan_on) begin
      // Disabled channel floats, driver turns both devices off
      pwm_out <= 1'b0;
      pwm_oe_n <= 1'b1;
    end else if (phase_clk) begin
      // Clock starts the pulse
      pwm_out <= 1'b1;
      pwm_oe_n <= 1'b0;
    end else if (pwm_out && ripple_hit) begin
      // Ripple at window level ends the pulse
      pwm_out <= 1'b0;
      pwm_oe_n <= !sync_mode;
    end else if (!pwm_out) begin
      // Off time: float in standard buck, drive low in synchronous buck
      pwm_oe_n <= !sync_mode;
    end
  end

endmodule : vrseq_phase

// ===== rtl/vrseq_top.sv
// Start-up sequencer, master clock distribution and channel control.
// Assumes all pins are asynchronous to clk_sys and a Wishbone master on clk_sys.
module vrseq_top #(
  parameter int NMAIN = 4, // Main rail channel count
  parameter int STRAP_WAIT = vrseq_pkg::STRAP_WAIT_CYC // Strap wait in cycles
) (
  input wire logic clk_sys,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog comparator and strap pins
  input wire logic bias_por_ok,
  input wire logic enable,
  input wire logic main_comp_reached,
  input wire logic aux_comp_reached,
  input wire logic [NMAIN:0] ripple_at_window,
  input wire logic [NMAIN-1:0] phase_sense_strap,
  input wire logic aux_sense_strap,
  input wire logic config_strap_a,
  input wire logic config_strap_b,
  // Serial voltage-ID link
  input wire logic vid_serial_clock,
  input wire logic vid_serial_data,
  input wire logic host_power_ok,
  output logic telem_data_out,
  output logic telem_data_oe_n,
  output logic voltage_change_ack,
  // Power stage side
  output logic main_ramp_restart,
  output logic aux_ramp_restart,
  output logic [NMAIN:0] pwm_out,
  output logic [NMAIN:0] pwm_oe_n,
  output logic continuous_mode_select,
  output logic [7:0] reference_code,
  output logic main_power_good,
  output logic aux_power_good
);
  import vrseq_pkg::*;

  // Refuse channel counts the rotation cannot serve
  if (NMAIN < 1 || NMAIN > 4) begin : g_bad_nmain
    $error("NMAIN must be 1 to 4");
  end
  if (STRAP_WAIT < 1) begin : g_bad_wait
    $error("STRAP_WAIT must be at least 1");
  end

  localparam int NSYNC = 2 * NMAIN + 11; // Synchronised pin count
  localparam int WAIT_W = $clog2(STRAP_WAIT + 1); // Wait counter width

  logic [NSYNC-1:0] pins_raw; // Raw pin vector
  logic [NSYNC-1:0] pins_s1; // First synchroniser stage
  logic [NSYNC-1:0] pins_s2; // Second synchroniser stage
  logic por_s, en_s, mcomp_s, acomp_s, vclk_s, vdat_s, pok_s; // Synced pins
  logic cfga_s, cfgb_s, astrap_s; // Synced straps
  logic [NMAIN:0] ripple_s; // Synced window comparators
  logic [NMAIN-1:0] strap_s; // Synced sense straps
  logic mcomp_d, acomp_d, vclk_d; // Edge detect history
  logic master_pulse, aux_pulse; // One-shot clocks
  logic vclk_rise, vclk_fall; // Link clock edges
  vrseq_state_e state; // Sequencer state
  logic [WAIT_W-1:0] wait_cnt; // Strap wait counter
  logic [15:0] step_cnt; // Soft-start step prescaler
  logic [15:0] ctrl; // Control register
  vrseq_vid_s vid; // Boot, target and present codes
  vrseq_cfg_s cfg; // Sampled configuration straps
  logic [1:0] phase_idx; // Next phase to clock
  logic [2:0] active_cnt; // Active main phases
  logic [NMAIN:0] phase_clk; // Per-channel clock pulses
  logic [NMAIN:0] chan_on; // Per-channel enable
  logic main_off; // Main rail disabled by strap
  logic sync_mode; // Synchronous buck after threshold
  logic [7:0] cmd_shift; // Incoming command bits
  logic [3:0] cmd_cnt; // Command bit count
  logic ack_pending; // Raised code waiting for ramp
  logic telem_on; // Telemetry phase reached
  logic [7:0] telem_shift; // Outgoing telemetry bits
  logic [3:0] telem_cnt; // Telemetry bit count
  logic running; // Rails switching
  logic wb_req; // New bus request

  // Pin vector in fixed order
  assign pins_raw = {aux_sense_strap, config_strap_b, config_strap_a, phase_sense_strap,
                     ripple_at_window, host_power_ok, vid_serial_data, vid_serial_clock,
                     aux_comp_reached, main_comp_reached, enable, bias_por_ok};

  // Two-stage synchroniser for every pin
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
    end else begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
    end
  end

  // Split the synchronised vector
  assign {astrap_s, cfgb_s, cfga_s, strap_s, ripple_s, pok_s, vdat_s, vclk_s,
          acomp_s, mcomp_s, en_s, por_s} = pins_s2;

  // Edge history of synchronised levels
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mcomp_d <= 1'b0;
      acomp_d <= 1'b0;
      vclk_d <= 1'b0;
    end else begin
      mcomp_d <= mcomp_s;
      acomp_d <= acomp_s;
      vclk_d <= vclk_s;
    end
  end

  assign master_pulse = mcomp_s && !mcomp_d;
  assign aux_pulse = acomp_s && !acomp_d;
  assign vclk_rise = vclk_s && !vclk_d;
  assign vclk_fall = !vclk_s && vclk_d;

  // Ramp restart pulses back to the analog ramps
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      main_ramp_restart <= 1'b0;
      aux_ramp_restart <= 1'b0;
    end else begin
      main_ramp_restart <= master_pulse;
      aux_ramp_restart <= aux_pulse;
    end
  end

  // Active phase count: first strapped channel ends the rail
  always_comb begin
    active_cnt = 3'(NMAIN);
    for (int i = NMAIN - 1; i >= 1; i--) begin
      if (strap_s[i]) begin
        active_cnt = 3'(i);
      end
    end
  end

  assign main_off = strap_s[0];
  assign running = (state == VRSEQ_RAMP) || (state == VRSEQ_GOOD) || (state == VRSEQ_RUN);

  // Rotating phase pointer
  always_ff @(posedge clk_sys) begin
    if (reset || !running) begin
      phase_idx <= 2'h0;
    end else if (master_pulse) begin
      if (3'(phase_idx) + 3'h1 >= active_cnt) begin
        phase_idx <= 2'h0; // single phase stays on one
      end else begin
        phase_idx <= phase_idx + 2'h1;
      end
    end
  end

  // Clock pulse and enable for each channel
  generate
    for (genvar g = 0; g <= NMAIN; g++) begin : g_chan
      if (g < NMAIN) begin : g_main
        assign phase_clk[g] = master_pulse && (phase_idx == 2'(g));
        assign chan_on[g] = running && !main_off && (g < active_cnt) && !strap_s[g];
      end else begin : g_aux
        assign phase_clk[g] = aux_pulse;
        assign chan_on[g] = running && !astrap_s;
      end
      vrseq_phase u_phase (
        .clk_sys(clk_sys),
        .reset(reset),
        .phase_clk(phase_clk[g]),
        .ripple_hit(ripple_s[g]),
        .chan_on(chan_on[g]),
        .sync_mode(sync_mode),
        .pwm_out(pwm_out[g]),
        .pwm_oe_n(pwm_oe_n[g])
      );
    end
  endgenerate

  // Start-up state machine
  always_ff @(posedge clk_sys) begin
    if (reset || !por_s || !en_s) begin
      state <= VRSEQ_OFF;
    end else begin
      case (state)
        VRSEQ_OFF: begin
          // Bias and enable both good, in either order
          state <= VRSEQ_STRAP;
        end
        VRSEQ_STRAP: begin
          // Strap window elapsed
          if (wait_cnt == WAIT_W'(STRAP_WAIT - 1)) begin
            state <= VRSEQ_RAMP;
          end
        end
        VRSEQ_RAMP: begin
          // Ramp reached boot level
          if (vid.dac == vid.target) begin
            state <= VRSEQ_GOOD;
          end
        end
        VRSEQ_GOOD: begin
          // Host confirms power
          if (pok_s) begin
            state <= VRSEQ_RUN;
          end
        end
        default: begin
          state <= VRSEQ_RUN;
        end
      endcase
    end
  end

  // Strap wait counter and strap sampling
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wait_cnt <= '0;
      cfg <= '0;
    end else if (state == VRSEQ_STRAP) begin
      wait_cnt <= wait_cnt + WAIT_W'(1);
      cfg <= '{cfg_b: cfgb_s, cfg_a: cfga_s};
    end else begin
      wait_cnt <= '0;
    end
  end

  // Reference codes: boot latch, soft-start and voltage moves
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      vid <= '0;
      step_cnt <= '0;
    end else if (state == VRSEQ_OFF) begin
      vid.dac <= 8'h00;
      step_cnt <= '0;
      if (por_s && en_s) begin
        vid.boot <= {vclk_s, vdat_s};
        vid.target <= BOOT_TABLE[{vclk_s, vdat_s, 3'h0} +: 8];
      end
    end else begin
      if (state == VRSEQ_RUN && cmd_cnt == VID_CMD_BITS - 4'h1 && vclk_rise) begin
        vid.target <= {cmd_shift[6:0], vdat_s};
      end
      if (state != VRSEQ_STRAP && vid.dac != vid.target) begin
        // Digital ramp, one code per slew interval
        if (step_cnt == {ctrl[15:CTRL_DIV_LSB], 8'hFF}) begin
          step_cnt <= '0;
          vid.dac <= (vid.dac < vid.target) ? vid.dac + 8'h01 : vid.dac - 8'h01;
        end else begin
          step_cnt <= step_cnt + 16'h0001;
        end
      end
    end
  end

  // Standard buck until the code first passes the threshold, synchronous from then until off
  always_ff @(posedge clk_sys) begin
    if (reset || state == VRSEQ_OFF) begin
      sync_mode <= 1'b0;
    end else if (vid.dac > SYNC_REF_CODE) begin
      sync_mode <= 1'b1;
    end
  end

  // Serial command receiver, live only after host power ok
  always_ff @(posedge clk_sys) begin
    if (reset || state != VRSEQ_RUN) begin
      cmd_shift <= 8'h00;
      cmd_cnt <= 4'h0;
    end else if (vclk_rise) begin
      cmd_shift <= {cmd_shift[6:0], vdat_s};
      cmd_cnt <= (cmd_cnt == VID_CMD_BITS - 4'h1) ? 4'h0 : cmd_cnt + 4'h1;
    end
  end

  // Acknowledge of a raised code once the ramp lands
  always_ff @(posedge clk_sys) begin
    if (reset || state != VRSEQ_RUN) begin
      ack_pending <= 1'b0;
      voltage_change_ack <= 1'b0;
    end else begin
      if (cmd_cnt == VID_CMD_BITS - 4'h1 && vclk_rise
          && {cmd_shift[6:0], vdat_s} > vid.target) begin
        ack_pending <= 1'b1;
      end else if (ack_pending && vid.dac == vid.target) begin
        ack_pending <= 1'b0;
      end
      voltage_change_ack <= ack_pending && (vid.dac == vid.target);
    end
  end

  // Telemetry of the present code, shifted out on link clock falls
  always_ff @(posedge clk_sys) begin
    if (reset || state != VRSEQ_RUN) begin
      telem_on <= 1'b0;
      telem_shift <= 8'h00;
      telem_cnt <= 4'h0;
      telem_data_out <= 1'b0;
      telem_data_oe_n <= 1'b1;
    end else begin
      if (voltage_change_ack) begin
        telem_on <= 1'b1;
      end
      telem_data_oe_n <= !telem_on;
      if (telem_on && vclk_fall) begin
        if (telem_cnt == 4'h0) begin
          telem_shift <= {vid.dac[6:0], 1'b0};
          telem_data_out <= vid.dac[7];
          telem_cnt <= TELEM_BITS - 4'h1;
        end else begin
          telem_shift <= {telem_shift[6:0], 1'b0};
          telem_data_out <= telem_shift[7];
          telem_cnt <= telem_cnt - 4'h1;
        end
      end
    end
  end

  // Status outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      main_power_good <= 1'b0;
      aux_power_good <= 1'b0;
      continuous_mode_select <= 1'b0;
      reference_code <= 8'h00;
    end else begin
      main_power_good <= (state == VRSEQ_GOOD || state == VRSEQ_RUN) && !main_off;
      aux_power_good <= (state == VRSEQ_GOOD || state == VRSEQ_RUN) && !astrap_s;
      continuous_mode_select <= ctrl[CTRL_CCM_BIT];
      reference_code <= vid.dac;
    end
  end

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Wishbone answer one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == REG_CTRL) begin
          wb_dat_o <= {16'h0000, ctrl};
        end else if (wb_adr_i == REG_STATUS) begin
          wb_dat_o <= {20'h00000, 1'(main_off), active_cnt, 1'(sync_mode),
                       1'(aux_power_good), 1'(main_power_good), 2'h0, 3'(state)};
        end else if (wb_adr_i == REG_VID) begin
          wb_dat_o <= {14'h0000, vid};
        end else if (wb_adr_i == REG_STRAP) begin
          wb_dat_o <= {25'h0000000, 1'(astrap_s), 2'(cfg), 4'(strap_s)};
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  // Control register writes with byte lanes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (wb_req && wb_we_i && wb_adr_i == REG_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl[15:8] <= wb_dat_i[15:8];
      end
    end
  end

endmodule : vrseq_top

// ===== verif/vrseq_top_asserts.sv
// Checker: timing relations at the sequencer top ports.
// Assumes a bind onto vrseq_top and one clk_sys domain.
module vrseq_top_asserts #(
  parameter int NMAIN = 4,
  parameter int STRAP_WAIT = 20
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic enable,
  input wire logic [NMAIN-1:0] phase_sense_strap,
  input wire logic main_ramp_restart,
  input wire logic [NMAIN:0] pwm_out,
  input wire logic [NMAIN:0] pwm_oe_n,
  input wire logic [7:0] reference_code,
  input wire logic voltage_change_ack,
  input wire logic main_power_good,
  input wire logic aux_power_good
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Bus answers one cycle after a taken request, for one cycle
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  // Enable low leaves every channel floating and power goods low
  AST_OFF: assert property ((!enable) [*5] |-> (&pwm_oe_n) && !main_power_good &&
    !aux_power_good) else $error("outputs active while disabled");
  // Master pulse reaches some main channel
  AST_MASTER: assert property (main_ramp_restart && main_power_good &&
    !phase_sense_strap[0] |-> ##[0:4] (|pwm_out[NMAIN-1:0])) else $error("master pulse lost");
  // After soft-start the first channel is always driven
  AST_SYNC_DRIVE: assert property (main_power_good && !phase_sense_strap[0] |->
    !pwm_oe_n[0]) else $error("pulse pin floats in synchronous mode");
  // Low reference: off-time floats
  AST_FLOAT: assert property (reference_code <= 8'h4C && $past(reference_code) <= 8'h4C &&
    !pwm_out[0] && !$past(pwm_out[0]) |-> pwm_oe_n[0]) else $error("off-time driven early");
  AST_DIS4: assert property (phase_sense_strap[NMAIN-1] [*5] |-> !pwm_out[NMAIN-1])
    else $error("strapped channel pulses");
  AST_MAIN_OFF: assert property (phase_sense_strap[0] [*5] |-> pwm_out[NMAIN-1:0] == '0)
    else $error("main rail pulses while strapped off");
  AST_PG_CODE: assert property ($rose(main_power_good) |-> reference_code >= 8'h80)
    else $error("power good before ramp end");
  AST_VCA_ONE: assert property (voltage_change_ack |=> !voltage_change_ack)
    else $error("change ack longer than one cycle");
endmodule : vrseq_top_asserts

bind vrseq_top vrseq_top_asserts #(.NMAIN(NMAIN), .STRAP_WAIT(STRAP_WAIT)) u_vrseq_top_asserts (
  .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .enable(enable), .phase_sense_strap(phase_sense_strap),
  .main_ramp_restart(main_ramp_restart), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n),
  .reference_code(reference_code), .voltage_change_ack(voltage_change_ack),
  .main_power_good(main_power_good), .aux_power_good(aux_power_good));

// ===== verif/vrseq_host_model.sv
// Far side: host on the voltage-ID link and the power stages.
// Assumes clk_sys at 50 MHz; link clock period 160 ns built from it.
module vrseq_host_model #(
  parameter int NMAIN = 4
) (
  input wire logic clk_sys,
  input wire logic [NMAIN:0] pwm_out,
  input wire logic [NMAIN:0] pwm_oe_n,
  input wire logic continuous_mode_select,
  input wire logic main_power_good,
  input wire logic aux_power_good,
  input wire logic telem_data_out,
  output logic [NMAIN:0] ripple_at_window,
  output logic host_power_ok,
  output logic vid_serial_clock,
  output logic vid_serial_data
);
  logic [NMAIN:0] on_dly [6]; // Pulse level delay line
  logic [NMAIN:0] high_on; // Upper device on
  logic [NMAIN:0] low_on; // Lower device on
  initial begin
    on_dly = '{default: '0};
    ripple_at_window = '0;
    host_power_ok = 1'h0;
    vid_serial_clock = 1'h0;
    vid_serial_data = 1'h0;
  end
  // Ripple reaches the window seven cycles into a pulse
  always @(posedge clk_sys) begin
    on_dly[0] <= high_on;
    for (int i = 1; i < 6; i++) on_dly[i] <= on_dly[i - 1];
    ripple_at_window <= on_dly[5] & high_on;
    host_power_ok <= main_power_good && aux_power_good;
  end
  // Stage decode: floating pin turns both devices off
  always_comb begin
    high_on = ~pwm_oe_n & pwm_out;
    low_on = ~pwm_oe_n & ~pwm_out & (continuous_mode_select ? '1 : on_dly[2]);
  end
  // Boot pattern parked on the link pins
  task automatic preset(input logic clk_v, input logic dat_v);
    vid_serial_clock <= clk_v;
    vid_serial_data <= dat_v;
  endtask : preset
  // One byte out MSB first; telemetry sampled late in each low phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    rx = '0;
    vid_serial_clock <= 1'h0;
    vid_serial_data <= tx[7];
    repeat (5) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      vid_serial_clock <= 1'h1;
      repeat (3) @(posedge clk_sys);
      vid_serial_clock <= 1'h0;
      vid_serial_data <= (i < 7) ? tx[3'(6 - i)] : ~tx[0];
      repeat (5) @(posedge clk_sys);
      rx = {rx[6:0], telem_data_out};
    end
  endtask : xfer
endmodule : vrseq_host_model

// ===== verif/test_vrseq_top.sv
// Directed bench: Wishbone tasks, start-up, rotation, command and telemetry.
// Assumes vrseq_host_model on the far side and the bound checker.
module test_vrseq_top import vrseq_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NM = 4; // Main channels
  localparam int SW = 20; // Short strap wait
  logic clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, reference_code, rx;
  logic [3:0] wb_sel_i, phase_sense_strap;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic bias_por_ok, enable, main_comp_reached, aux_comp_reached, aux_sense_strap;
  logic config_strap_a, config_strap_b, vid_serial_clock, vid_serial_data, host_power_ok;
  logic telem_data_out, telem_data_oe_n, voltage_change_ack, main_ramp_restart;
  logic aux_ramp_restart, continuous_mode_select, main_power_good, aux_power_good;
  logic [NM:0] ripple_at_window, pwm_out, pwm_oe_n, pwm_q;
  int fails, samples_checked, cyc;
  int order[$]; // Main channels in firing order
  vrseq_top #(.NMAIN(NM), .STRAP_WAIT(SW)) u_vrseq_top (.clk_sys(clk_sys), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .bias_por_ok(bias_por_ok), .enable(enable), .main_comp_reached(main_comp_reached),
    .aux_comp_reached(aux_comp_reached), .ripple_at_window(ripple_at_window),
    .phase_sense_strap(phase_sense_strap), .aux_sense_strap(aux_sense_strap),
    .config_strap_a(config_strap_a), .config_strap_b(config_strap_b),
    .vid_serial_clock(vid_serial_clock), .vid_serial_data(vid_serial_data),
    .host_power_ok(host_power_ok), .telem_data_out(telem_data_out),
    .telem_data_oe_n(telem_data_oe_n), .voltage_change_ack(voltage_change_ack),
    .main_ramp_restart(main_ramp_restart), .aux_ramp_restart(aux_ramp_restart),
    .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .continuous_mode_select(continuous_mode_select),
    .reference_code(reference_code), .main_power_good(main_power_good),
    .aux_power_good(aux_power_good));
  vrseq_host_model #(.NMAIN(NM)) u_vrseq_host_model (.clk_sys(clk_sys), .pwm_out(pwm_out),
    .pwm_oe_n(pwm_oe_n), .continuous_mode_select(continuous_mode_select),
    .main_power_good(main_power_good), .aux_power_good(aux_power_good),
    .telem_data_out(telem_data_out), .ripple_at_window(ripple_at_window),
    .host_power_ok(host_power_ok), .vid_serial_clock(vid_serial_clock),
    .vid_serial_data(vid_serial_data));
  // Clock, 20 ns period
  always #10 clk_sys = ~clk_sys;
  // Comparator trips every 40 cycles; firing order recorded
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    main_comp_reached <= (cyc % 40) < 2;
    aux_comp_reached <= (cyc % 40) inside {20, 21};
    pwm_q <= pwm_out;
    for (int i = 0; i < NM; i++) if (pwm_out[i] && !pwm_q[i]) order.push_back(i);
  end
  // Compare one value
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // One classic Wishbone cycle, held until ack
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] rd);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wd;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'h1) begin
      @(posedge clk_sys);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_sys);
  endtask : wb_cycle
  // Reconfigure main phases behind a main-off strap, then watch the rotation
  task automatic rotate(input logic [3:0] strap, input int n);
    phase_sense_strap <= strap | 4'h1;
    repeat (50) @(posedge clk_sys);
    check("main off", 32'hF, {28'h0, pwm_oe_n[3:0]});
    check("main pg off", '0, {31'h0, main_power_good});
    phase_sense_strap <= strap;
    repeat (10) @(posedge clk_sys);
    order.delete();
    repeat (400) @(posedge clk_sys);
    check("pulses", 32'h1, {31'h0, order.size() >= 6});
    for (int k = 0; k + 1 < order.size(); k++)
      check("rotation", (order[k] + 1) % n, order[k + 1]);
  endtask : rotate
  // Verdict and end of run
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  // Watchdog
  initial begin
    repeat (80000) @(posedge clk_sys);
    fails++;
    wrap_up();
  end
  // Main sequence
  initial begin
    logic [31:0] d;
    int t0;
    {clk_sys, wb_cyc_i, wb_stb_i, wb_we_i, bias_por_ok, enable, aux_sense_strap} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, cyc, fails, samples_checked} = '0;
    {main_comp_reached, aux_comp_reached, config_strap_b} = '0;
    config_strap_a = 1'h1;
    phase_sense_strap = 4'h8;
    reset = 1'h1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    check("oe_n reset", {27'h0, 5'h1F}, {27'h0, pwm_oe_n});
    wb_cycle(1'h0, REG_CTRL, '0, d);
    check("ctrl reset", {16'h0, CTRL_RESET}, d);
    wb_cycle(1'h1, REG_STATUS, 32'hFFFFFFFF, d);
    wb_cycle(1'h0, REG_STATUS, '0, d);
    check("status off", '0, d & 32'hFF);
    wb_cycle(1'h0, 8'hFC, '0, d);
    check("unmapped", '0, d);
    wb_cycle(1'h1, REG_CTRL, 32'h0, d);
    check("diode select", '0, {31'h0, continuous_mode_select});
    wb_cycle(1'h1, REG_CTRL, 32'h1, d);
    check("ccm select", 32'h1, {31'h0, continuous_mode_select});
    u_vrseq_host_model.preset(1'h1, 1'h0);
    bias_por_ok <= 1'h1;
    repeat (4) @(posedge clk_sys);
    enable <= 1'h1;
    t0 = cyc;
    repeat (3) @(posedge clk_sys);
    wb_cycle(1'h0, REG_STATUS, '0, d);
    check("strap state", {29'h0, VRSEQ_STRAP}, {29'h0, d[2:0]});
    while (d[2:0] !== VRSEQ_RAMP && cyc - t0 < 200) wb_cycle(1'h0, REG_STATUS, '0, d);
    check("strap wait", 32'h1, {31'h0, cyc - t0 >= SW && cyc - t0 <= SW + 12});
    check("phases", 32'h3, {29'h0, d[10:8]});
    wb_cycle(1'h0, REG_STRAP, '0, d);
    check("straps", 32'h18, d & 32'h7F);
    t0 = cyc;
    while (main_power_good !== 1'h1 && cyc - t0 < 60000) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    check("main_power_good", 32'h1, {30'h0, main_power_good, aux_power_good} >> 1);
    check("aux main_power_good", 32'h1, {31'h0, aux_power_good});
    check("boot code", {24'h0, BOOT_TABLE[23:16]}, {24'h0, reference_code});
    wb_cycle(1'h0, REG_VID, '0, d);
    check("vid reg", 32'h2A0, (d >> 8) & 32'h3FF);
    order.delete();
    repeat (400) @(posedge clk_sys);
    check("pulse count", 32'h1, {31'h0, order.size() >= 6});
    for (int k = 0; k + 1 < order.size(); k++)
      check("phase order", (order[k] + 1) % 3, order[k + 1]);
    u_vrseq_host_model.xfer(8'hA8, rx);
    t0 = cyc;
    while (voltage_change_ack !== 1'h1 && cyc - t0 < 5000) @(posedge clk_sys);
    check("change ack", 32'h1, {31'h0, voltage_change_ack});
    check("new code", 32'hA8, {24'h0, reference_code});
    repeat (3) @(posedge clk_sys);
    check("telem drive", '0, {31'h0, telem_data_oe_n});
    u_vrseq_host_model.xfer(8'hA8, rx);
    check("telemetry", 32'hA8, {24'h0, rx});
    rotate(4'h4, 2);
    rotate(4'h2, 1);
    rotate(4'h0, 4);
    enable <= 1'h0;
    repeat (8) @(posedge clk_sys);
    check("oe_n off", {27'h0, 5'h1F}, {27'h0, pwm_oe_n});
    check("main_power_good off", '0, {31'h0, main_power_good});
    wrap_up();
  end
endmodule : test_vrseq_top
